/* File: hdl/lcd_instruction_executor.sv */
// Instruction executor of a one-line character display controller, AXI4-Lite slave
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
module lcd_instruction_executor #(
	parameter int ADDR_W      = 8,
	parameter int OSC_DIV     = lcd_exec_pkg::OSC_DIV,
	parameter int BLINK_TICKS = lcd_exec_pkg::BLINK_TICKS
) (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	logic              rst_meta_q;
	logic              rst_n_q;
	logic              aw_full_q;
	logic              w_full_q;
	logic [5:0]        aw_idx_q;
	logic [7:0]        w_byte_q;
	logic              w_lane_q;
	logic              commit;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic [5:0]        ar_idx;
	logic [6:0]        ram_pointer_q;
	logic [3:0]        offset_q;
	logic              increment_q;
	logic              shift_en_q;
	logic              display_on_q;
	logic              cursor_on_q;
	logic              blink_on_q;
	logic              blink_phase_q;
	logic [4:0]        exec_cnt_q;
	logic              execution_pending;
	logic [3:0]        view_pos_q;
	logic [7:0]        character_code_ram [lcd_exec_pkg::CC_DEPTH];
	logic [4:0]        user_pattern_ram   [lcd_exec_pkg::UP_DEPTH];
	logic [4:0]        icon_ram           [lcd_exec_pkg::ICON_DEPTH];
	logic              osc_tick;
	logic              blink_tick;
	logic              do_instr;
	logic              do_write;
	logic              do_read;
	logic              in_cc;
	logic              in_up;
	logic              in_icon;
	logic [6:0]        ptr_step;
	logic [3:0]        off_left;
	logic [3:0]        off_right;
	logic [7:0]        ram_rd;
	logic [4:0]        view_sum;
	logic [3:0]        view_cc;
	logic [4:0]        cur_sum;
	logic [3:0]        cur_panel;
	logic              cur_here;
	logic [31:0]       view_word;
	logic [31:0]       rd_word;
	logic [4:0]        exec_load;

	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Internal oscillator rate and blink period
	pulse_divider #(.WIDTH(16), .DIV(OSC_DIV)) osc_div (
		.clk_sys (clk_sys),
		.rst_n   (rst_n_q),
		.en      (1'b1),
		.tick    (osc_tick)
	);

	pulse_divider #(.WIDTH(16), .DIV(BLINK_TICKS)) blink_div (
		.clk_sys (clk_sys),
		.rst_n   (rst_n_q),
		.en      (osc_tick),
		.tick    (blink_tick)
	);

	// Handshakes; one write and one read at a time
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take  = s_axi_wvalid & s_axi_wready;
	assign commit  = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign ar_idx  = s_axi_araddr[lcd_exec_pkg::REG_IDX_LSB +: 6];

	// Write address and data capture, either order
	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			aw_idx_q      <= 6'h00;
			w_byte_q      <= 8'h00;
			w_lane_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_full_q <= 1'b1;
				aw_idx_q  <= s_axi_awaddr[lcd_exec_pkg::REG_IDX_LSB +: 6];
			end
			else if (commit)
			begin
				aw_full_q <= 1'b0;
			end
			if (w_take)
			begin
				w_full_q <= 1'b1;
				w_byte_q <= s_axi_wdata[7:0];
				w_lane_q <= s_axi_wstrb[0];
			end
			else if (commit)
			begin
				w_full_q <= 1'b0;
			end
			s_axi_awready <= commit | (~aw_full_q & ~aw_take);
			s_axi_wready  <= commit | (~w_full_q & ~w_take);
		end
	end

	// Write response; unmapped offsets answer SLVERR
	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= lcd_exec_pkg::RESP_OKAY;
		end
		else if (commit)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_idx_q > lcd_exec_pkg::REG_VIEW) ?
				lcd_exec_pkg::RESP_SLVERR : lcd_exec_pkg::RESP_OKAY;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Requests that start execution; refused silently while busy
	assign do_instr = commit & w_lane_q & ~execution_pending & (aw_idx_q == lcd_exec_pkg::REG_INSTR);
	assign do_write = commit & w_lane_q & ~execution_pending & (aw_idx_q == lcd_exec_pkg::REG_DATA);
	assign do_read  = ar_take & ~execution_pending & (ar_idx == lcd_exec_pkg::REG_DATA);

	assign in_cc   = (ram_pointer_q <= lcd_exec_pkg::CC_LAST);
	assign in_up   = (ram_pointer_q >= lcd_exec_pkg::UP_FIRST) &
		(ram_pointer_q <= lcd_exec_pkg::UP_LAST);
	assign in_icon = (ram_pointer_q >= lcd_exec_pkg::ICON_FIRST) &
		(ram_pointer_q <= lcd_exec_pkg::ICON_LAST);

	// Pointer step and shift offset neighbours, offset wraps modulo twelve
	assign ptr_step  = increment_q ? ram_pointer_q + 7'h01 : ram_pointer_q - 7'h01;
	assign off_left  = (offset_q == 4'hb) ? 4'h0 : offset_q + 4'h1;
	assign off_right = (offset_q == 4'h0) ? 4'hb : offset_q - 4'h1;

	// RAM read mux at the pointer
	always_comb
	begin
		ram_rd = 8'h00;
		if (in_cc)
			ram_rd = character_code_ram[ram_pointer_q[3:0]];
		else if (in_up)
			ram_rd = {3'b000, user_pattern_ram[ram_pointer_q[4:0]]};
		else if (in_icon)
			ram_rd = {3'b000, icon_ram[3'(ram_pointer_q - lcd_exec_pkg::ICON_FIRST)]};
	end

	// Instruction effects on pointer and shift offset
	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ram_pointer_q <= 7'h00;
			offset_q      <= 4'h0;
		end
		else if (do_instr)
		begin
			if (w_byte_q[lcd_exec_pkg::OP_ADDR])
				ram_pointer_q <= w_byte_q[6:0];
			else if (w_byte_q[7:5] != 3'b000)
				ram_pointer_q <= ram_pointer_q;
			else if (w_byte_q[lcd_exec_pkg::OP_SHIFT])
			begin
				if (w_byte_q[lcd_exec_pkg::F_DISP_SEL])
					offset_q <= w_byte_q[lcd_exec_pkg::F_RIGHT] ? off_right : off_left;
				else
					ram_pointer_q <= w_byte_q[lcd_exec_pkg::F_RIGHT] ?
						ram_pointer_q + 7'h01 : ram_pointer_q - 7'h01;
			end
			else if (w_byte_q[3:2] != 2'b00)
				ram_pointer_q <= ram_pointer_q;
			else if (w_byte_q[lcd_exec_pkg::OP_HOME] | w_byte_q[lcd_exec_pkg::OP_CLEAR])
			begin
				// home and clear go to left end
				ram_pointer_q <= lcd_exec_pkg::CC_FIRST;
				offset_q      <= 4'h0;
			end
		end
		else if (do_write)
		begin
			ram_pointer_q <= ptr_step;
			if (shift_en_q & in_cc)
				offset_q <= increment_q ? off_left : off_right;
		end
		else if (do_read)
		begin
			ram_pointer_q <= ptr_step;
		end
	end

	// Entry mode and display control flags
	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			increment_q  <= 1'b1;
			shift_en_q   <= 1'b0;
			display_on_q <= 1'b0;
			cursor_on_q  <= 1'b0;
			blink_on_q   <= 1'b0;
		end
		else if (do_instr & (w_byte_q[7:4] == 4'h0))
		begin
			if (w_byte_q[lcd_exec_pkg::OP_CTRL])
			begin
				display_on_q <= w_byte_q[lcd_exec_pkg::F_DISPLAY];
				cursor_on_q  <= w_byte_q[lcd_exec_pkg::F_CURSOR];
				blink_on_q   <= w_byte_q[lcd_exec_pkg::F_BLINK];
			end
			else if (w_byte_q[lcd_exec_pkg::OP_ENTRY])
			begin
				increment_q <= w_byte_q[lcd_exec_pkg::F_INCREMENT];
				shift_en_q  <= w_byte_q[lcd_exec_pkg::F_SHIFT_EN];
			end
			else if (w_byte_q[3:0] == 4'h1)
				// only direction changes, shift enable kept
				increment_q <= 1'b1;
		end
	end

	// RAM contents; clear touches character RAM only
	always_ff @(posedge clk_sys)
	begin
		if (do_instr & (w_byte_q == 8'h01))
		begin
			for (int i = 0; i < lcd_exec_pkg::CC_DEPTH; i++)
				character_code_ram[i] <= lcd_exec_pkg::SPACE_CODE;
		end
		else if (do_write)
		begin
			// only data writes change the pattern and icon RAMs
			if (in_cc)
				character_code_ram[ram_pointer_q[3:0]] <= w_byte_q;
			else if (in_up)
				user_pattern_ram[ram_pointer_q[4:0]] <= w_byte_q[4:0];
			else if (in_icon)
				icon_ram[3'(ram_pointer_q - lcd_exec_pkg::ICON_FIRST)] <= w_byte_q[4:0];
		end
	end

	// Execution time in oscillator ticks per accepted request
	always_comb
	begin
		exec_load = 5'h00;
		if (do_write)
			exec_load = 5'(lcd_exec_pkg::TICK_WRITE);
		else if (do_read)
			exec_load = 5'(lcd_exec_pkg::TICK_READ);
		else if (do_instr)
		begin
			if (w_byte_q[lcd_exec_pkg::OP_ADDR])
				exec_load = 5'(lcd_exec_pkg::TICK_ADDR);
			else if (w_byte_q[7:5] != 3'b000)
				exec_load = 5'h00;
			else if (w_byte_q[lcd_exec_pkg::OP_SHIFT])
				exec_load = 5'(lcd_exec_pkg::TICK_SHIFT);
			else if (w_byte_q != 8'h00)
				exec_load = 5'(lcd_exec_pkg::TICK_OTHER);
		end
	end

	// busy from acceptance until count runs out
	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
			exec_cnt_q <= 5'h00;
		else if (exec_load != 5'h00)
			exec_cnt_q <= exec_load;
		else if (osc_tick & (exec_cnt_q != 5'h00))
			exec_cnt_q <= exec_cnt_q - 5'h01;
	end

	assign execution_pending = (exec_cnt_q != 5'h00);

	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
			blink_phase_q <= 1'b0;
		else if (blink_tick)
			blink_phase_q <= ~blink_phase_q;
	end

	// Panel position picked by software for inspection
	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
			view_pos_q <= 4'h0;
		else if (commit & w_lane_q & (aw_idx_q == lcd_exec_pkg::REG_VIEW))
			view_pos_q <= (w_byte_q[3:0] > 4'hb) ? 4'hb : w_byte_q[3:0];
	end

	// Panel position to character RAM slot, and cursor panel slot
	assign view_sum  = {1'b0, view_pos_q} + {1'b0, offset_q};
	assign view_cc   = (view_sum >= 5'd12) ? 4'(view_sum - 5'd12) : view_sum[3:0];
	assign cur_sum   = {1'b0, ram_pointer_q[3:0]} + 5'd12 - {1'b0, offset_q};
	assign cur_panel = (cur_sum >= 5'd12) ? 4'(cur_sum - 5'd12) : cur_sum[3:0];
	assign cur_here  = in_cc & (cur_panel == view_pos_q);

	// What the chosen panel position shows
	always_comb
	begin
		view_word = 32'h0000_0000;
		if (display_on_q)
		begin
			view_word[lcd_exec_pkg::VW_ON] = 1'b1;
			view_word[7:0] = character_code_ram[view_cc];
			view_word[lcd_exec_pkg::VW_CURSOR] = cur_here;
			if (cursor_on_q & cur_here)
				view_word[lcd_exec_pkg::VW_DOTS +: 5] = lcd_exec_pkg::CURSOR_DOTS;
			view_word[lcd_exec_pkg::VW_SOLID] = blink_on_q & blink_phase_q & cur_here;
		end
	end

	// Read mux
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (ar_idx)
			lcd_exec_pkg::REG_INSTR:
				rd_word = {24'h000000, execution_pending, ram_pointer_q};
			lcd_exec_pkg::REG_DATA:
				rd_word = {24'h000000, ram_rd};
			lcd_exec_pkg::REG_STATUS:
			begin
				rd_word[lcd_exec_pkg::ST_BLINK]  = blink_on_q;
				rd_word[lcd_exec_pkg::ST_CURSOR] = cursor_on_q;
				rd_word[lcd_exec_pkg::ST_DISP]   = display_on_q;
				rd_word[lcd_exec_pkg::ST_SHIFT]  = shift_en_q;
				rd_word[lcd_exec_pkg::ST_INC]    = increment_q;
				rd_word[lcd_exec_pkg::ST_OFF +: 4] = offset_q;
				rd_word[lcd_exec_pkg::ST_PHASE]  = blink_phase_q;
				rd_word[lcd_exec_pkg::ST_BUSY]   = execution_pending;
			end
			lcd_exec_pkg::REG_VIEW:
				rd_word = view_word;
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	// Read channel, data registered one cycle after address
	always_ff @(posedge clk_sys or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= lcd_exec_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~ar_take & ~(s_axi_rvalid & ~s_axi_rready);
			if (ar_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= (ar_idx > lcd_exec_pkg::REG_VIEW) ?
					lcd_exec_pkg::RESP_SLVERR : lcd_exec_pkg::RESP_OKAY;
			end
			else if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* File: hdl/lcd_exec_pkg.sv */
// Package with register map, instruction fields, RAM map and timing constants
package lcd_exec_pkg;

	// Register word indices; the bus byte address is four times the index
	localparam logic [5:0] REG_INSTR   = 6'h00; // Write instruction, read busy and pointer
	localparam logic [5:0] REG_DATA    = 6'h01; // Write or read RAM data
	localparam logic [5:0] REG_STATUS  = 6'h02; // Control flags and shift offset
	localparam logic [5:0] REG_VIEW    = 6'h03; // Write panel position, read what it shows
	localparam int         REG_IDX_LSB = 2;

	// Instruction opcode bit positions, decoded by highest set bit
	localparam int OP_CLEAR = 0;
	localparam int OP_HOME  = 1;
	localparam int OP_ENTRY = 2;
	localparam int OP_CTRL  = 3;
	localparam int OP_SHIFT = 4;
	localparam int OP_ADDR  = 7;

	// Operand field positions
	localparam int F_SHIFT_EN  = 0;
	localparam int F_INCREMENT = 1;
	localparam int F_BLINK     = 0;
	localparam int F_CURSOR    = 1;
	localparam int F_DISPLAY   = 2;
	localparam int F_RIGHT     = 2;
	localparam int F_DISP_SEL  = 3;

	// RAM map
	localparam logic [6:0] CC_FIRST   = 7'h00;
	localparam logic [6:0] CC_LAST    = 7'h0b;
	localparam logic [6:0] UP_FIRST   = 7'h40;
	localparam logic [6:0] UP_LAST    = 7'h5f;
	localparam logic [6:0] ICON_FIRST = 7'h60;
	localparam logic [6:0] ICON_LAST  = 7'h64;
	localparam int         CC_DEPTH   = 12;
	localparam int         UP_DEPTH   = 32;
	localparam int         ICON_DEPTH = 5;
	localparam logic [7:0] SPACE_CODE = 8'h20;

	// Status register fields
	localparam int ST_BLINK  = 0;
	localparam int ST_CURSOR = 1;
	localparam int ST_DISP   = 2;
	localparam int ST_SHIFT  = 3;
	localparam int ST_INC    = 4;
	localparam int ST_OFF    = 8;
	localparam int ST_PHASE  = 16;
	localparam int ST_BUSY   = 24;
	localparam int INSTR_BUSY = 7;

	// View register fields
	localparam int         VW_DOTS   = 8;
	localparam int         VW_SOLID  = 13;
	localparam int         VW_ON     = 14;
	localparam int         VW_CURSOR = 15;
	localparam logic [4:0] CURSOR_DOTS = 5'h1f;

	// Clock, oscillator and execution times
	localparam int CLK_HZ      = 50_000_000;
	localparam int OSC_HZ      = 45_000;
	localparam int OSC_DIV     = CLK_HZ / OSC_HZ;
	localparam int T_ADDR_US   = 223;
	localparam int T_WRITE_US  = 223;
	localparam int T_READ_US   = 312;
	localparam int T_SHIFT_US  = 312;
	localparam int T_OTHER_US  = 223;
	localparam int BLINK_MS    = 540;
	localparam int TICK_ADDR   = (T_ADDR_US * OSC_HZ + 999_999) / 1_000_000;
	localparam int TICK_WRITE  = (T_WRITE_US * OSC_HZ + 999_999) / 1_000_000;
	localparam int TICK_READ   = (T_READ_US * OSC_HZ + 999_999) / 1_000_000;
	localparam int TICK_SHIFT  = (T_SHIFT_US * OSC_HZ + 999_999) / 1_000_000;
	localparam int TICK_OTHER  = (T_OTHER_US * OSC_HZ + 999_999) / 1_000_000;
	localparam int BLINK_TICKS = (BLINK_MS * OSC_HZ) / 1000;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: hdl/pulse_divider.sv */
// Enable divider: one-cycle pulse every DIV enabled cycles
module pulse_divider #(
	parameter int WIDTH = 16,
	parameter int DIV   = 1111
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic en,
	output logic      tick
);
	logic [WIDTH-1:0] count_q;

	// Count enabled cycles, wrap at DIV
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= '0;
			tick    <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (en)
			begin
				if (count_q == WIDTH'(DIV - 1))
				begin
					count_q <= '0;
					tick    <= 1'b1;
				end
				else
				begin
					count_q <= count_q + WIDTH'(1);
				end
			end
		end
	end
endmodule

/* File: verification/lcd_exec_chk.sv */
// Checker on the executor's register port
module lcd_exec_chk #(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_sys,
	input wire logic              reset_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready
);
	logic [ADDR_W-1:0] ar_q;
	logic              view;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// Address of the read in flight, to decode its answer
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			ar_q <= '0;
		else if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	end
	// Any byte of the view word decodes to the view register
	assign view = s_axi_rvalid && ar_q[7:2] == 6'h03;

	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer moved");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer moved");
	// Both halves taken together: answer two edges later
	property p_b_time;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_time: assert property (p_b_time) else $error("write answer late");
	property p_r_time;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_time: assert property (p_r_time) else $error("read answer late");
	property p_aw_drop;
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
	property p_ar_err;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h03
			|=> s_axi_rresp == lcd_exec_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_ar_err: assert property (p_ar_err) else $error("unmapped read not refused");
	property p_view_off;
		view && !s_axi_rdata[14] |-> s_axi_rdata == 32'h0;
	endproperty
	a_view_off: assert property (p_view_off) else $error("blank panel shows data");
	property p_view_dots;
		view && s_axi_rdata[12:8] != 5'h0 |-> s_axi_rdata[12:8] == 5'h1f && s_axi_rdata[15];
	endproperty
	a_view_dots: assert property (p_view_dots) else $error("cursor dots wrong");
	property p_view_solid;
		view && s_axi_rdata[13] |-> s_axi_rdata[15] && s_axi_rdata[14];
	endproperty
	a_view_solid: assert property (p_view_solid) else $error("blink away from cursor");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_cursor: cover property (view && s_axi_rdata[15]);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == lcd_exec_pkg::RESP_SLVERR);
	c_solid: cover property (view && s_axi_rdata[13]);
endmodule

bind lcd_instruction_executor lcd_exec_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: verification/lite_host.sv */
// Host model: register bus master that issues instructions and polls busy
module lite_host (
	input  wire logic        clk_sys,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hung;
	logic slow;

	// Quiet bus at time zero
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, hung, slow} = '0;
		s_axi_wstrb = 4'hf;
	end

	// Each channel held until taken; a slow host raises ready late
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge clk_sys);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= !slow;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (n == 3)
				s_axi_bready <= 1'b1;
			n++;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 64);
		r = s_axi_bresp;
		hung |= !s_axi_bvalid;
		// Released lines no longer show the old payload
		s_axi_bready <= 1'b0;
		s_axi_awaddr <= ~a;
		s_axi_wdata  <= ~{24'h0, d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge clk_sys);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= !slow;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (n == 3)
				s_axi_rready <= 1'b1;
			n++;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 64);
		d = s_axi_rdata;
		r = s_axi_rresp;
		hung |= !s_axi_rvalid;
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~a;
	endtask

	task automatic idle();
		logic [31:0] d;
		logic [1:0]  r;
		int n = 0;
		do
		begin
			rd(8'h00, d, r);
			n++;
		end while (d[7] && n < 40);
		hung |= d[7];
	endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the display instruction executor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OSC = 4;

	logic        clk_sys;
	logic        reset_n;
	wire [7:0]   s_axi_awaddr, s_axi_araddr;
	wire [31:0]  s_axi_wdata, s_axi_rdata;
	wire [3:0]   s_axi_wstrb;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire         s_axi_rvalid, s_axi_rready;
	logic [31:0] rv;
	logic [1:0]  rr;
	logic [7:0]  cc [12];
	logic [7:0]  a;
	logic [7:0]  b;
	logic [1:0]  r;
	logic        s0;
	logic        s1;
	int          failures = 0;
	int          checked = 0;
	int          cyc = 0;
	int          t0;

	lcd_instruction_executor #(.OSC_DIV(OSC), .BLINK_TICKS(4)) i_lcd_instruction_executor (.*);
	lite_host host (.*);

	function automatic logic [31:0] st_exp(input logic [4:0] f, input logic [3:0] o);
		return {20'h0, o, 3'h0, f};
	endfunction
	// Solid-phase bit is left out: its phase is free running
	function automatic logic [31:0] vw_exp(input logic c, input logic [7:0] ch);
		return {16'h0, c, 2'b10, {5{c}}, ch};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c);
		host.slow = 1'($urandom);
		host.wr(8'h00, c, rr);
		chk("bresp", 32'h0, {30'h0, rr});
		host.idle();
	endtask
	task automatic dw(input logic [7:0] d);
		host.wr(8'h04, d, rr);
		host.idle();
	endtask
	task automatic dread();
		host.rd(8'h04, rv, rr);
		host.idle();
		rv = {24'h0, rv[7:0]};
	endtask
	task automatic ptr_is(input logic [6:0] e);
		host.rd(8'h00, rv, rr);
		chk("pointer", {25'h0, e}, {25'h0, rv[6:0]});
		chk("rresp", 32'h0, {30'h0, rr});
	endtask
	task automatic st_is(input logic [4:0] f, input logic [3:0] o);
		host.rd(8'h08, rv, rr);
		chk("status", st_exp(f, o), rv & 32'h0f1f);
	endtask
	task automatic vw_is(input logic [3:0] p, input logic [31:0] e);
		host.wr(8'h0c, {4'h0, p}, rr);
		host.rd(8'h0c, rv, rr);
		chk("view", e, rv & ~32'h2000);
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever
			#10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		cyc <= cyc + 1;
	// A stuck handshake or a run-away run ends the test
	always @(posedge clk_sys)
		if (host.hung || cyc > 60000)
		begin
			failures++;
			finish_test();
		end

	initial
	begin
		reset_n = 1'b0;
		void'($urandom(19));
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		st_is(5'h10, 4'h0);
		host.wr(8'h10, 8'h00, rr);
		chk("bresp", 32'h2, {30'h0, rr});
		host.rd(8'h10, rv, rr);
		chk("rresp", 32'h2, {30'h0, rr});
		host.wr(8'h08, 8'h07, rr);
		st_is(5'h10, 4'h0);
		cmd(8'h07);
		cmd(8'h01);
		st_is(5'h18, 4'h0);
		cmd(8'h80);
		for (int i = 0; i < 12; i++)
		begin
			dread();
			chk("space", 32'h20, rv);
		end
		ptr_is(7'h0c);
		st_is(5'h18, 4'h0);
		cmd(8'h06);
		cmd(8'h80);
		for (int i = 0; i < 12; i++)
		begin
			cc[i] = 8'($urandom);
			dw(cc[i]);
		end
		cmd(8'h80);
		for (int i = 0; i < 12; i++)
		begin
			dread();
			chk("char", {24'h0, cc[i]}, rv);
		end
		cmd(8'h04);
		cmd(8'h85);
		cc[5] = 8'($urandom);
		dw(cc[5]);
		ptr_is(7'h04);
		cmd(8'h07);
		cc[4] = 8'($urandom);
		dw(cc[4]);
		st_is(5'h18, 4'h1);
		cmd(8'h05);
		cc[5] = 8'($urandom);
		dw(cc[5]);
		st_is(5'h08, 4'h0);
		r = 2'($urandom);
		cmd({6'h04, r});
		ptr_is(7'h03);
		cmd({6'h05, r});
		ptr_is(7'h04);
		cmd({6'h06, r});
		st_is(5'h08, 4'h1);
		ptr_is(7'h04);
		cmd({7'h01, r[0]});
		ptr_is(7'h00);
		st_is(5'h08, 4'h0);
		cmd(8'h0f);
		st_is(5'h0f, 4'h0);
		vw_is(4'h0, vw_exp(1'b1, cc[0]));
		vw_is(4'h3, vw_exp(1'b0, cc[3]));
		cmd(8'h0b);
		vw_is(4'h3, 32'h0);
		cmd(8'h0f);
		vw_is(4'h3, vw_exp(1'b0, cc[3]));
		{s0, s1} = 2'b00;
		repeat (16)
		begin
			host.rd(8'h08, rv, rr);
			s1 |= rv[16];
			s0 |= !rv[16];
		end
		chk("blink", 32'h3, {30'h0, s0, s1});
		a = 8'($urandom) & 8'h1f;
		b = 8'($urandom) & 8'h1f;
		cmd(8'hdf);
		dw(a);
		cmd(8'he4);
		dw(b);
		st_is(5'h0f, 4'h0);
		cmd(8'h01);
		st_is(5'h1f, 4'h0);
		vw_is(4'h0, vw_exp(1'b1, 8'h20));
		cmd(8'hdf);
		dread();
		chk("pattern", {24'h0, a}, rv);
		cmd(8'he4);
		dread();
		chk("icon", {24'h0, b}, rv);
		host.wr(8'h00, 8'h83, rr);
		host.wr(8'h00, 8'h88, rr);
		host.idle();
		ptr_is(7'h03);
		host.wr(8'h00, 8'h80, rr);
		t0 = cyc;
		host.rd(8'h00, rv, rr);
		chk("busy", 32'h1, {31'h0, rv[7]});
		host.idle();
		t0 = cyc - t0;
		chk("busy_time", 32'h1, {31'h0, t0 >= 10 * OSC && t0 <= 11 * OSC + 8});
		finish_test();
	end
endmodule
